// ---- include/acss_params.svh ----
// offsets, field positions, reset values and preset divisors of the clock source selector
`ifndef ACSS_PARAMS_SVH
`define ACSS_PARAMS_SVH
`define ACSS_RATE_W 20
`define ACSS_ERR_W 16
`define ACSS_NREF 6
`define ACSS_NLOCK 4
`define ACSS_NCHAN 28
`define ACSS_NIRQ 3
// register byte offsets
`define ACSS_OFF_STATUS 8'h00
`define ACSS_OFF_CTRL 8'h04
`define ACSS_OFF_SYNTH 8'h08
`define ACSS_OFF_BASE 8'h0C
`define ACSS_OFF_COARSE 8'h10
`define ACSS_OFF_FINE 8'h14
`define ACSS_OFF_ACT_RATE 8'h18
`define ACSS_OFF_INT_RATE 8'h1C
`define ACSS_OFF_WCLK 8'h20
`define ACSS_OFF_CHAN 8'h24
`define ACSS_OFF_IRQ_ST 8'h28
`define ACSS_OFF_IRQ_MASK 8'h2C
`define ACSS_OFF_FLASH 8'h30
// control word fields
`define ACSS_CTRL_AUTO 0
`define ACSS_CTRL_PREF 1
`define ACSS_CTRL_WCSS 4
`define ACSS_CTRL_BW 5
`define ACSS_CTRL_SPIN 7
`define ACSS_CTRL_SPOUT 8
// synthesizer word fields
`define ACSS_SYN_EN 0
`define ACSS_SYN_MULT 1
`define ACSS_SYN_COARSE 3
`define ACSS_SYN_FINE 4
`define ACSS_SYN_PRESET 5
// status word fields
`define ACSS_ST_SRC 8
`define ACSS_ST_SLAVE 11
`define ACSS_ST_ERR 12
`define ACSS_ST_CNT 16
// interrupt bits
`define ACSS_IRQ_SRC 0
`define ACSS_IRQ_ERR 1
`define ACSS_IRQ_FLASH 2
// reset values, rate figures in hertz and preset pull divisors
`define ACSS_BASE_RST 20'h0BB80
`define ACSS_WC_BAND_HI 20'h0BB80
`define ACSS_PULL_SMALL_DIV 1000
`define ACSS_PULL_LARGE_DIV 25
// flash image
`define ACSS_FLASH_WORDS 6
`define ACSS_FLASH_SIG 32'hA5C3_0001
`endif

// ---- include/acss_pkg.sv ----
// types shared by the clock source selector design
`include "acss_params.svh"
package acss_pkg;
  typedef logic [`ACSS_RATE_W-1:0] acss_rate_t;
  // reference sources, internal last
  typedef enum logic [2:0] {SRC_WCLK, SRC_OPT1, SRC_OPT2, SRC_SPDIF, SRC_LTC, SRC_VIDEO,
    SRC_INTERNAL} acss_src_e;
  typedef enum logic [1:0] {LOCK_NONE, LOCK_VALID, LOCK_SYNC} acss_lock_e;
  typedef enum logic [2:0] {PRE_NONE, PRE_UP_SMALL, PRE_DN_SMALL, PRE_UP_LARGE,
    PRE_DN_LARGE} acss_preset_e;
  typedef enum logic [1:0] {FL_IDLE, FL_SAVE, FL_LOAD_A, FL_LOAD_D} acss_fl_e;
  // every control and synthesizer setting, the unit that flash saves and restores
  typedef struct packed {
    logic auto_follow_mode;
    logic [2:0] pref_ref;
    logic wc_single;
    logic [1:0] bw_set;
    logic spdif_in_opt2;
    logic spdif_out_opt2;
    logic synth_en;
    logic [1:0] mult;
    logic coarse_act;
    logic fine_act;
    logic [2:0] preset;
    acss_rate_t base;
    logic signed [`ACSS_RATE_W-1:0] coarse;
    logic signed [`ACSS_RATE_W-1:0] fine;
  } acss_cfg_s;
  // whole state of the top module
  typedef struct packed {
    acss_cfg_s cfg;
    logic [`ACSS_NREF-1:0] v_s1, v_s2, v_s3, valid;
    logic [`ACSS_NLOCK-1:0] y_s1, y_s2, y_s3, insync;
    logic t_s1, t_s2, t_s3, timecode_option_module;
    acss_src_e src;
    logic slave;
    logic [`ACSS_ERR_W-1:0] err_cnt;
    logic [`ACSS_NIRQ-1:0] irq_st;
    logic [`ACSS_NIRQ-1:0] irq_mask;
    acss_fl_e fl;
    logic [2:0] fl_idx;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    acss_rate_t int_rate;
    acss_rate_t act_rate;
    acss_rate_t wclk;
    logic [`ACSS_NCHAN-1:0] chan_en;
  } acss_st_s;
endpackage

// ---- logic/acss_flash_mem.sv ----
// settings store standing in for the on-board nonvolatile flash
`timescale 1ns/100ps
`default_nettype none
module acss_flash_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] addr, // word address
  input wire logic [WIDTH-1:0] wdata, // write data
  output logic [WIDTH-1:0] rdata // registered read data
);
  // no reset on purpose: contents model storage that survives power loss
  logic [WIDTH-1:0] mem [DEPTH];

  // one write or read per cycle, read data one cycle later
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ---- logic/acss_top.sv ----
// clock source selection, lock status, rate synthesizer and settings store
`timescale 1ns/100ps
`include "acss_params.svh"
`default_nettype none
// Function
// - internal master or auto-follow preferred reference
// - invalid preferred reference falls to next valid
// - word clock, optical pair, SPDIF; timecode optional
// - three-state lock report per input
// - report active source and its rate
// - report master or slave state
// - count link errors, clear on transfer start
// - word clock out, optional single-speed band
// - four channel sets for link bandwidth
// - every setting write acts at once
// - restore replaces settings from flash
// - save to flash, load after power-on
// - synth rate: base times multiplier plus fader
// - synthesized rate only in master mode
// - synth enable and per-fader activate bits
// - pull-up/down presets of 0.1 and 4 percent
// - SPDIF input from coax or second optical
// - SPDIF out on coax, optionally second optical
// - no valid reference reverts to internal master
module acss_top import acss_pkg::*; #(
  parameter int FLASH_DEPTH = 8,
  parameter acss_rate_t INT_BASE_HZ = `ACSS_BASE_RST
) (
  input wire logic hclk, // bus and system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write not read
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  input wire logic [`ACSS_NREF-1:0] ref_valid_pin, // per-reference valid, async
  input wire logic [`ACSS_NLOCK-1:0] ref_sync_pin, // per-input synchronous, async
  input wire logic tco_fitted_pin, // timecode option module present, async
  input wire acss_rate_t [`ACSS_NREF-1:0] ref_rate_hz, // measured rates, same clock
  input wire logic link_err, // host link error pulse
  input wire logic xfer_start, // playback or record start pulse
  output logic run_internal, // internal clock in use
  output acss_src_e active_clock_source, // clock currently in use
  output acss_rate_t internal_rate_hz, // internal clock rate
  output acss_rate_t wclk_out_hz, // word clock output rate
  output logic [`ACSS_NCHAN-1:0] chan_enable, // link channels carried
  output logic spdif_rx_opt2, // SPDIF receiver from second optical
  output logic opt2_tx_spdif, // second optical transmits SPDIF
  output logic coax_tx_en, // coax SPDIF output enable
  output logic irq // level interrupt
);
  if (FLASH_DEPTH < `ACSS_FLASH_WORDS)
  begin : g_chk
    $error("FLASH_DEPTH too small for the settings image");
  end

  localparam int AW = $clog2(FLASH_DEPTH);

  acss_st_s q, d; // state and its next value
  logic [31:0] fl_rdata; // flash read word
  logic fl_we; // flash write strobe
  logic [31:0] fl_wdata; // flash write word

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // settings word by image index, also the bus view of the settings registers
  function automatic logic [31:0] cfg_word(input logic [2:0] idx, input acss_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      3'h0: w = `ACSS_FLASH_SIG;
      3'h1:
      begin
        w[`ACSS_CTRL_AUTO] = c.auto_follow_mode;
        w[`ACSS_CTRL_PREF +: 3] = c.pref_ref;
        w[`ACSS_CTRL_WCSS] = c.wc_single;
        w[`ACSS_CTRL_BW +: 2] = c.bw_set;
        w[`ACSS_CTRL_SPIN] = c.spdif_in_opt2;
        w[`ACSS_CTRL_SPOUT] = c.spdif_out_opt2;
      end
      3'h2:
      begin
        w[`ACSS_SYN_EN] = c.synth_en;
        w[`ACSS_SYN_MULT +: 2] = c.mult;
        w[`ACSS_SYN_COARSE] = c.coarse_act;
        w[`ACSS_SYN_FINE] = c.fine_act;
        w[`ACSS_SYN_PRESET +: 3] = c.preset;
      end
      3'h3: w[`ACSS_RATE_W-1:0] = c.base;
      3'h4: w = {{(32-`ACSS_RATE_W){c.coarse[`ACSS_RATE_W-1]}}, c.coarse};
      3'h5: w = {{(32-`ACSS_RATE_W){c.fine[`ACSS_RATE_W-1]}}, c.fine};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // inverse of cfg_word, used by bus writes and flash restore alike
  function automatic acss_cfg_s cfg_apply(input logic [2:0] idx, input logic [31:0] w,
    input acss_cfg_s c);
    acss_cfg_s r;
    r = c;
    case (idx)
      3'h1:
      begin
        r.auto_follow_mode = w[`ACSS_CTRL_AUTO];
        r.pref_ref = w[`ACSS_CTRL_PREF +: 3];
        r.wc_single = w[`ACSS_CTRL_WCSS];
        r.bw_set = w[`ACSS_CTRL_BW +: 2];
        r.spdif_in_opt2 = w[`ACSS_CTRL_SPIN];
        r.spdif_out_opt2 = w[`ACSS_CTRL_SPOUT];
      end
      3'h2:
      begin
        r.synth_en = w[`ACSS_SYN_EN];
        r.mult = w[`ACSS_SYN_MULT +: 2];
        r.coarse_act = w[`ACSS_SYN_COARSE];
        r.fine_act = w[`ACSS_SYN_FINE];
        r.preset = w[`ACSS_SYN_PRESET +: 3];
      end
      3'h3: r.base = w[`ACSS_RATE_W-1:0];
      3'h4: r.coarse = w[`ACSS_RATE_W-1:0];
      3'h5: r.fine = w[`ACSS_RATE_W-1:0];
      default: r = c;
    endcase
    return r;
  endfunction

  // first valid reference at or after the preferred one, wrapping round
  function automatic logic [3:0] pick_src(input logic [`ACSS_NREF-1:0] v,
    input logic [2:0] pref);
    logic [3:0] r;
    logic [2:0] k;
    r = {1'b0, 3'(SRC_INTERNAL)};
    for (int i = `ACSS_NREF - 1; i >= 0; i--)
    begin
      k = 3'((32'(pref) + 32'(i)) % `ACSS_NREF);
      if (v[k])
      begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // settings store

  assign fl_we = (q.fl == FL_SAVE);
  assign fl_wdata = cfg_word(q.fl_idx, q.cfg);

  acss_flash_mem #(
    .DEPTH(FLASH_DEPTH),
    .WIDTH(32)
  ) u_flash (
    .clk(hclk),
    .we(fl_we),
    .addr(AW'(q.fl_idx)),
    .wdata(fl_wdata),
    .rdata(fl_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [3:0] pick;
    logic [`ACSS_NREF-1:0] cand;
    logic [`ACSS_NIRQ-1:0] ev;
    logic signed [24:0] rate;
    logic [31:0] rd;
    logic take;
    pick = 4'h0;
    cand = '0;
    ev = '0;
    rate = '0;
    rd = 32'h0000_0000;
    take = 1'b0;
    d = q;
    // pins pass three stages; a level counts once stages two and three agree
    d.v_s1 = ref_valid_pin;
    d.v_s2 = q.v_s1;
    d.v_s3 = q.v_s2;
    d.y_s1 = ref_sync_pin;
    d.y_s2 = q.y_s1;
    d.y_s3 = q.y_s2;
    d.t_s1 = tco_fitted_pin;
    d.t_s2 = q.t_s1;
    d.t_s3 = q.t_s2;
    for (int i = 0; i < `ACSS_NREF; i++)
    begin
      if (q.v_s2[i] == q.v_s3[i])
      begin
        d.valid[i] = q.v_s3[i];
      end
    end
    for (int i = 0; i < `ACSS_NLOCK; i++)
    begin
      if (q.y_s2[i] == q.y_s3[i])
      begin
        d.insync[i] = q.y_s3[i];
      end
    end
    if (q.t_s2 == q.t_s3)
    begin
      d.timecode_option_module = q.t_s3;
    end
    cand = q.valid;
    cand[SRC_LTC] = q.valid[SRC_LTC] & q.timecode_option_module;
    cand[SRC_VIDEO] = q.valid[SRC_VIDEO] & q.timecode_option_module;
    pick = pick_src(cand, q.cfg.pref_ref);
    d.slave = q.cfg.auto_follow_mode & pick[3];
    d.src = d.slave ? acss_src_e'(pick[2:0]) : SRC_INTERNAL;
    ev[`ACSS_IRQ_SRC] = (d.src != q.src);
    rate = 25'(q.cfg.base) <<< ((q.cfg.mult == 2'h3) ? 2 : q.cfg.mult);
    case (acss_preset_e'(q.cfg.preset))
      PRE_UP_SMALL: rate = 25'(rate + rate / `ACSS_PULL_SMALL_DIV);
      PRE_DN_SMALL: rate = 25'(rate - rate / `ACSS_PULL_SMALL_DIV);
      PRE_UP_LARGE: rate = 25'(rate + rate / `ACSS_PULL_LARGE_DIV);
      PRE_DN_LARGE: rate = 25'(rate - rate / `ACSS_PULL_LARGE_DIV);
      default: rate = rate;
    endcase
    if (q.cfg.coarse_act)
    begin
      rate = rate + 25'(q.cfg.coarse);
    end
    if (q.cfg.fine_act)
    begin
      rate = rate + 25'(q.cfg.fine);
    end
    d.int_rate = (q.cfg.synth_en && !q.cfg.auto_follow_mode) ?
      acss_rate_t'(rate) : INT_BASE_HZ;
    d.act_rate = q.slave ? ref_rate_hz[q.src] : q.int_rate;
    d.wclk = q.act_rate;
    if (q.cfg.wc_single)
    begin
      if (q.act_rate > (`ACSS_WC_BAND_HI << 1))
      begin
        d.wclk = q.act_rate >> 2;
      end
      else if (q.act_rate > `ACSS_WC_BAND_HI)
      begin
        d.wclk = q.act_rate >> 1;
      end
    end
    case (q.cfg.bw_set)
      2'h0: d.chan_en = 28'hFFF_FFFF;
      2'h1: d.chan_en = 28'h00F_FFFF;
      2'h2: d.chan_en = 28'h000_0FFF;
      default: d.chan_en = 28'h000_00FF;
    endcase
    // error counter, an error in the start cycle still counts
    if (xfer_start)
    begin
      d.err_cnt = '0;
    end
    if (link_err && d.err_cnt != '1)
    begin
      d.err_cnt = d.err_cnt + 1'b1;
    end
    ev[`ACSS_IRQ_ERR] = link_err;
    // settings store sequencer
    case (q.fl)
      FL_SAVE:
      begin
        d.fl_idx = q.fl_idx + 3'h1;
        if (q.fl_idx == 3'(`ACSS_FLASH_WORDS - 1))
        begin
          d.fl = FL_IDLE;
          ev[`ACSS_IRQ_FLASH] = 1'b1;
        end
      end
      FL_LOAD_A: d.fl = FL_LOAD_D;
      FL_LOAD_D:
      begin
        // replace settings from flash
        // match tested first, so an unreadable word 0 aborts as well
        if (q.fl_idx == 3'h0 && fl_rdata == `ACSS_FLASH_SIG)
        begin
          d.fl_idx = 3'h1;
          d.fl = FL_LOAD_A;
        end
        else if (q.fl_idx == 3'h0)
        begin
          d.fl = FL_IDLE;
        end
        else if (q.fl_idx == 3'(`ACSS_FLASH_WORDS - 1))
        begin
          d.cfg = cfg_apply(q.fl_idx, fl_rdata, q.cfg);
          d.fl = FL_IDLE;
          ev[`ACSS_IRQ_FLASH] = 1'b1;
        end
        else
        begin
          d.cfg = cfg_apply(q.fl_idx, fl_rdata, q.cfg);
          d.fl_idx = q.fl_idx + 3'h1;
          d.fl = FL_LOAD_A;
        end
      end
      default: d.fl = FL_IDLE;
    endcase
    // bus data phase: writes land here
    if (q.a_wr)
    begin
      if (q.a_addr >= `ACSS_OFF_CTRL && q.a_addr <= `ACSS_OFF_FINE)
      begin
        d.cfg = cfg_apply(q.a_addr[4:2], hwdata, d.cfg);
      end
      else if (q.a_addr == `ACSS_OFF_IRQ_ST)
      begin
        d.irq_st = q.irq_st & ~hwdata[`ACSS_NIRQ-1:0];
      end
      else if (q.a_addr == `ACSS_OFF_IRQ_MASK)
      begin
        d.irq_mask = hwdata[`ACSS_NIRQ-1:0];
      end
      else if (q.a_addr == `ACSS_OFF_FLASH && q.fl == FL_IDLE)
      begin
        // restore on bit 0, save on bit 1; busy store ignores commands
        if (hwdata[0])
        begin
          d.fl = FL_LOAD_A;
          d.fl_idx = 3'h0;
        end
        else if (hwdata[1])
        begin
          d.fl = FL_SAVE;
          d.fl_idx = 3'h0;
        end
      end
    end
    // events set after the clear, so a set in the clear cycle wins
    d.irq_st = d.irq_st | ev;
    d.irq = |(q.irq_st & q.irq_mask);
    // bus address phase: capture, and fetch read data for the data phase
    take = hsel & hready & htrans[1];
    d.a_wr = take & hwrite;
    d.a_addr = haddr[7:0];
    if (take && !hwrite)
    begin
      if (haddr[7:0] == `ACSS_OFF_STATUS)
      begin
        for (int i = 0; i < `ACSS_NLOCK; i++)
        begin
          rd[2*i +: 2] = !q.valid[i] ? LOCK_NONE : (q.insync[i] ? LOCK_SYNC : LOCK_VALID);
        end
        rd[`ACSS_ST_SRC +: 3] = q.src;
        rd[`ACSS_ST_SLAVE] = q.slave;
        rd[`ACSS_ST_ERR] = (q.err_cnt != '0);
        rd[`ACSS_ST_CNT +: `ACSS_ERR_W] = q.err_cnt;
      end
      else if (haddr[7:0] >= `ACSS_OFF_CTRL && haddr[7:0] <= `ACSS_OFF_FINE)
      begin
        rd = cfg_word(haddr[4:2], q.cfg);
      end
      else if (haddr[7:0] == `ACSS_OFF_ACT_RATE)
      begin
        rd[`ACSS_RATE_W-1:0] = q.act_rate;
      end
      else if (haddr[7:0] == `ACSS_OFF_INT_RATE)
      begin
        rd[`ACSS_RATE_W-1:0] = q.int_rate;
      end
      else if (haddr[7:0] == `ACSS_OFF_WCLK)
      begin
        rd[`ACSS_RATE_W-1:0] = q.wclk;
      end
      else if (haddr[7:0] == `ACSS_OFF_CHAN)
      begin
        rd[`ACSS_NCHAN-1:0] = q.chan_en;
      end
      else if (haddr[7:0] == `ACSS_OFF_IRQ_ST)
      begin
        rd[`ACSS_NIRQ-1:0] = q.irq_st;
      end
      else if (haddr[7:0] == `ACSS_OFF_IRQ_MASK)
      begin
        rd[`ACSS_NIRQ-1:0] = q.irq_mask;
      end
      else if (haddr[7:0] == `ACSS_OFF_FLASH)
      begin
        rd[0] = (q.fl != FL_IDLE);
      end
      // unmapped addresses read zero
    end
    d.hrdata = rd;
    d.hreadyout = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset starts a flash load so saved settings return after power-on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.cfg.base <= `ACSS_BASE_RST;
      q.src <= SRC_INTERNAL;
      q.int_rate <= `ACSS_BASE_RST;
      q.act_rate <= `ACSS_BASE_RST;
      q.wclk <= `ACSS_BASE_RST;
      q.chan_en <= 28'hFFF_FFFF;
      q.hreadyout <= 1'b1;
      q.fl <= FL_LOAD_A;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all but hresp from the state register

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign run_internal = ~q.slave;
  assign active_clock_source = q.src;
  assign internal_rate_hz = q.int_rate;
  assign wclk_out_hz = q.wclk;
  assign chan_enable = q.chan_en;
  assign spdif_rx_opt2 = q.cfg.spdif_in_opt2;
  assign opt2_tx_spdif = q.cfg.spdif_out_opt2;
  assign coax_tx_en = q.hreadyout;
  assign irq = q.irq;
endmodule
`default_nettype wire

// ---- sim/acss_top_checker.sv ----
// port-level assertions for the clock source selector
`timescale 1ns/100ps
`include "acss_params.svh"
`default_nettype none
module acss_top_checker import acss_pkg::*; #(
  parameter acss_rate_t INT_BASE_HZ = `ACSS_BASE_RST
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [`ACSS_NREF-1:0] ref_valid_pin, // valid pins
  input wire logic tco_fitted_pin, // option fitted pin
  input wire logic run_internal, // master flag
  input wire acss_src_e active_clock_source, // source in use
  input wire acss_rate_t internal_rate_hz, // internal rate
  input wire logic [`ACSS_NCHAN-1:0] chan_enable, // channel mask
  input wire logic coax_tx_en // coax output enable
);
  logic [3:0] nv_q; // cycles with no valid pin, saturating
  logic [3:0] nt_q; // cycles without the option, saturating
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////
  // quiet counters; the pin synchronisers hide the first few cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nv_q <= 4'h0;
      nt_q <= 4'h0;
    end
    else
    begin
      nv_q <= (ref_valid_pin != '0) ? 4'h0 : nv_q + {3'h0, nv_q != 4'hF};
      nt_q <= tco_fitted_pin ? 4'h0 : nt_q + {3'h0, nt_q != 4'hF};
    end
  end
  //////////////////////////////////////////////////////////////////
  property p_zero_wait;
    hreadyout && !hresp;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus stalled or error");
  property p_coax;
    coax_tx_en;
  endproperty
  a_coax: assert property (p_coax) else $error("coax output dropped");
  property p_chan_set;
    chan_enable inside {28'hFFFFFFF, 28'h00FFFFF, 28'h0000FFF, 28'h00000FF};
  endproperty
  a_chan_set: assert property (p_chan_set) else $error("channel mask not a set");
  property p_reset_state;
    $rose(hresetn) |-> run_internal && active_clock_source == SRC_INTERNAL && &chan_enable;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  property p_mode_flag;
    run_internal == (active_clock_source == SRC_INTERNAL);
  endproperty
  a_mode_flag: assert property (p_mode_flag) else $error("mode flag disagrees");
  property p_revert;
    nv_q >= 4'hA |-> run_internal;
  endproperty
  a_revert: assert property (p_revert) else $error("slave with no valid ref");
  property p_slave_rate;
    $fell(run_internal) ##2 !run_internal |-> internal_rate_hz == INT_BASE_HZ;
  endproperty
  a_slave_rate: assert property (p_slave_rate) else $error("synth rate in slave");
  property p_no_option;
    nt_q >= 4'h8 |-> !(active_clock_source inside {SRC_LTC, SRC_VIDEO});
  endproperty
  a_no_option: assert property (p_no_option) else $error("timecode ref unfitted");
endmodule
bind acss_top acss_top_checker #(.INT_BASE_HZ(INT_BASE_HZ)) i_chk (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .ref_valid_pin(ref_valid_pin),
  .tco_fitted_pin(tco_fitted_pin), .run_internal(run_internal),
  .active_clock_source(active_clock_source), .internal_rate_hz(internal_rate_hz),
  .chan_enable(chan_enable), .coax_tx_en(coax_tx_en));
`default_nettype wire

// ---- sim/acss_ref_model.sv ----
// behavioural model of the external reference sources
`timescale 1ns/100ps
`include "acss_params.svh"
`default_nettype none
module acss_ref_model import acss_pkg::*; (
  input wire logic hclk, // system clock
  input wire logic [`ACSS_NREF-1:0] on_req, // sources plugged in
  input wire logic [`ACSS_NLOCK-1:0] sync_req, // sources in step
  input wire logic tco_req, // option module fitted
  output logic [`ACSS_NREF-1:0] ref_valid_pin, // valid per source
  output logic [`ACSS_NLOCK-1:0] ref_sync_pin, // synchronous per source
  output logic tco_fitted_pin, // option present
  output acss_rate_t [`ACSS_NREF-1:0] ref_rate_hz // measured rates
);
  logic [19:0] junk_q = 20'h5A5A5; // dead sources show this, never a stale rate
  //////////////////////////////////////////////////////////////////
  // changing pattern so a dead rate can not look plausible
  always_ff @(posedge hclk)
  begin
    junk_q <= ~junk_q;
  end
  // six sources, last two need the option
  // sync reported only on a valid signal
  always_comb
  begin
    tco_fitted_pin = tco_req;
    ref_valid_pin = on_req & {tco_req, tco_req, 4'hF};
    ref_sync_pin = sync_req & ref_valid_pin[3:0];
    for (int i = 0; i < `ACSS_NREF; i++)
    begin
      ref_rate_hz[i] = ref_valid_pin[i] ? 20'h0AC44 + 20'h003E8 * i[19:0] : junk_q;
    end
  end
endmodule
`default_nettype wire

// ---- sim/audio_clock_source_select_tb.sv ----
// self-checking bench for the clock source selector
`timescale 1ns/100ps
`include "acss_params.svh"
`default_nettype none
module audio_clock_source_select_tb import acss_pkg::*;;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tco_req = 1'b0;
  logic link_err = 1'b0, xfer_start = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2; // word transfers only
  logic [5:0] on_req = 6'h00, vld;
  logic [3:0] sync_req = 4'h0, syn;
  logic hreadyout, hresp, run_internal, rx2, tx2, coax, irq, timecode_option_module;
  acss_src_e src;
  acss_rate_t irate, wclk;
  acss_rate_t [5:0] rates;
  logic [27:0] chan;
  logic [2:0] pr [5] = '{3'h0, 3'h3, 3'h4, 3'h4, 3'h2}; // preferred refs
  logic [2:0] ex [5] = '{3'h1, 3'h3, 3'h1, 3'h4, 3'h3}; // sources expected
  logic [27:0] cs [4] = '{28'hFFFFFFF, 28'h00FFFFF, 28'h0000FFF, 28'h00000FF};
  logic [55:0] sy [12] = '{56'h01_00_0BB80_0BB80, 56'h03_10_17700_0BB80,
    56'h07_10_2EE00_0BB80, 56'h03_00_17700_17700, 56'h0D_00_2EE64_2EE64,
    56'h19_00_0BBDF_0BBDF, 56'h21_00_0BBB0_0BBB0, 56'h41_00_0BB50_0BB50,
    56'h61_00_0C300_0C300, 56'h81_00_0B400_0B400, 56'h18_00_0BB80_0BB80,
    56'h07_01_0BB80_0BB80}; // synth word, ctrl, internal rate, word clock
  int error_cnt = 0, checked = 0, cyc = 0;
  always #5 hclk = ~hclk;
  acss_ref_model i_src (.hclk(hclk), .on_req(on_req), .sync_req(sync_req), .tco_req(tco_req),
    .ref_valid_pin(vld), .ref_sync_pin(syn), .tco_fitted_pin(timecode_option_module), .ref_rate_hz(rates));
  acss_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ref_valid_pin(vld), .ref_sync_pin(syn),
    .tco_fitted_pin(timecode_option_module), .ref_rate_hz(rates), .link_err(link_err), .xfer_start(xfer_start),
    .run_internal(run_internal), .active_clock_source(src), .internal_rate_hz(irate),
    .wclk_out_hz(wclk), .chan_enable(chan), .spdif_rx_opt2(rx2), .opt2_tx_spdif(tx2),
    .coax_tx_en(coax), .irq(irq));
  //////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; the bus wait has no bound of its own, the hang guard cuts it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // write, then let dependent outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (4) @(posedge hclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic pulse(input logic e, input logic x);
    @(posedge hclk);
    link_err <= e;
    xfer_start <= x;
    @(posedge hclk);
    link_err <= 1'b0;
    xfer_start <= 1'b0;
  endtask
  task automatic errs(input logic [15:0] n);
    repeat (2) @(posedge hclk);
    bus(1'b0, `ACSS_OFF_STATUS, 32'h0);
    chk("err_cnt", {rd[31:16], rd[12]}, {n, n != 16'h0});
  endtask
  task automatic flash(input logic [31:0] cmd);
    wr(`ACSS_OFF_FLASH, cmd);
    do bus(1'b0, `ACSS_OFF_FLASH, 32'h0); while (rd[0] !== 1'b0);
    repeat (4) @(posedge hclk);
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
    chk("master", {run_internal, src}, {1'b1, SRC_INTERNAL});
    rdc("base", `ACSS_OFF_BASE, 32'h0BB80);
    rdc("unmapped", 8'h40, 32'h0);
    on_req <= 6'h1A;
    sync_req <= 4'h2;
    for (int i = 0; i < 5; i++)
    begin
      tco_req <= (i == 3);
      wr(`ACSS_OFF_CTRL, {28'h0, pr[i], 1'b1});
      repeat (8) @(posedge hclk);
      chk("slave", {run_internal, src}, {1'b0, ex[i]});
      rdc("status", `ACSS_OFF_STATUS, {20'h0, 1'b1, ex[i], 8'h48});
      rdc("act_rate", `ACSS_OFF_ACT_RATE, {12'h0, 20'h0AC44 + 20'h003E8 * ex[i]});
    end
    on_req <= 6'h00;
    repeat (12) @(posedge hclk);
    chk("revert", {run_internal, src}, {1'b1, SRC_INTERNAL});
    // errors counted, masked, cleared on start
    wr(`ACSS_OFF_IRQ_ST, 32'h7);
    repeat (3) pulse(1'b1, 1'b0);
    errs(16'h3);
    chk("irq_masked", irq, 1'b0);
    wr(`ACSS_OFF_IRQ_MASK, 32'h2);
    chk("irq_on", irq, 1'b1);
    pulse(1'b1, 1'b1);
    errs(16'h1);
    pulse(1'b0, 1'b1);
    errs(16'h0);
    wr(`ACSS_OFF_IRQ_ST, 32'h2);
    chk("irq_off", irq, 1'b0);
    wr(`ACSS_OFF_COARSE, 32'h64);
    wr(`ACSS_OFF_FINE, 32'hFFFFFFFB);
    for (int i = 0; i < 12; i++)
    begin
      wr(`ACSS_OFF_CTRL, {24'h0, sy[i][47:40]});
      wr(`ACSS_OFF_SYNTH, {24'h0, sy[i][55:48]});
      chk("rates", {irate, wclk}, sy[i][39:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`ACSS_OFF_CTRL, {23'h0, i[1:0], i[1:0], 5'h0});
      chk("route", {chan, rx2, tx2, coax}, {cs[i], i[0], i[1], 1'b1});
    end
    flash(32'h2);
    wr(`ACSS_OFF_CTRL, 32'h0);
    flash(32'h1);
    rdc("restored", `ACSS_OFF_CTRL, 32'h1E0);
    chk("restored_chan", chan, 28'h00000FF);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (30) @(posedge hclk);
    rdc("power_on", `ACSS_OFF_CTRL, 32'h1E0);
    chk("power_on_chan", chan, 28'h00000FF);
    final_report;
  end
endmodule
`default_nettype wire
